/* File: hdl/sit_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sit_defs.svh"
module sit_timer
#(
	parameter int TICK_CYC = `SIT_TICK_CYC,
	parameter int LP_INT_CYC = `SIT_LP_INT_CYC
)
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic [13:0] WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK,
	input wire logic LP_CLK_PIN,
	output logic OSC_WAKE,
	output logic PERIOD_END,
	output logic SLEEPING
);
	// ****************************************************************
	// Bus decode and configuration registers
	// ****************************************************************
	sit_pkg::sit_cfg_t cfg; // Software configuration.
	logic [1:0] coarse_top; // Upper coarse bits, fixed at zero here.
	logic start_req; // Begin-sleep request, lives one cycle.
	logic [11:0] idx; // Word index of the access.
	logic wr; // Write strobe for the accepted cycle.
	logic wake_flag; // Sticky wake-match flag.
	logic end_flag; // Sticky end-of-period flag.
	sit_pkg::sit_state_t state; // Sequencer state.
	logic wake_set; // Match seen this cycle.
	logic end_set; // Period ended this cycle.

	assign idx = WB_ADR[13:2];
	assign wr = WB_CYC && WB_STB && !WB_ACK && WB_WE && WB_SEL[0];
	assign coarse_top = 2'h0;

	// Ack one cycle after the request and drop it the cycle after.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			WB_ACK <= 1'b0;
		else
			WB_ACK <= WB_CYC && WB_STB && !WB_ACK;
	end

	// Register writes; reserved bits are dropped so they read back zero.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			cfg.wake_match_value <= 11'({`SIT_WAKE_HIGH_RST, `SIT_WAKE_LOW_RST});
			cfg.fine_tick_count <= {`SIT_BYTE_RST, `SIT_BYTE_RST};
			cfg.coarse_sleep_count <= {`SIT_BYTE_RST, `SIT_BYTE_RST, `SIT_BYTE_RST};
			cfg.beacon_order <= `SIT_BO_RST;
			cfg.slotted <= 1'b0;
			cfg.beacon_run <= 1'b0;
			cfg.low_power_clock_select <= `SIT_SEL_INTERNAL;
			cfg.low_power_clock_divider <= 5'h00;
		end
		else if (wr)
		begin
			case (idx)
				`SIT_IDX_WAKE_LOW: cfg.wake_match_value[7:0] <= WB_DAT_I[7:0];
				`SIT_IDX_WAKE_HIGH: cfg.wake_match_value[10:8] <= WB_DAT_I[2:0];
				`SIT_IDX_FINE_LOW: cfg.fine_tick_count[7:0] <= WB_DAT_I[7:0];
				`SIT_IDX_FINE_HIGH: cfg.fine_tick_count[15:8] <= WB_DAT_I[7:0];
				`SIT_IDX_COARSE0: cfg.coarse_sleep_count[7:0] <= WB_DAT_I[7:0];
				`SIT_IDX_COARSE1: cfg.coarse_sleep_count[15:8] <= WB_DAT_I[7:0];
				`SIT_IDX_COARSE2: cfg.coarse_sleep_count[23:16] <= WB_DAT_I[7:0];
				`SIT_IDX_CONTROL:
				begin
					cfg.beacon_run <= WB_DAT_I[`SIT_CTL_RUN];
					cfg.slotted <= WB_DAT_I[`SIT_CTL_SLOTTED];
					cfg.low_power_clock_select <= WB_DAT_I[`SIT_CTL_SEL_LSB +: 2];
				end
				`SIT_IDX_MODE:
				begin
					cfg.beacon_order <= WB_DAT_I[`SIT_MODE_BO_LSB +: 4];
					cfg.low_power_clock_divider <= WB_DAT_I[8 + `SIT_MODE_DIV_LSB +: 5];
				end
				default:
				begin
					// Unmapped writes are acknowledged and ignored.
				end
			endcase
		end
	end

	// The begin bit never stores; it acts only in non-beacon configuration.
	// Slotted lands in the same write, so its new value decides, not the old one.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			start_req <= 1'b0;
		else
			start_req <= wr && idx == `SIT_IDX_CONTROL && WB_DAT_I[`SIT_CTL_START]
				&& cfg.beacon_order == `SIT_BO_NONBEACON && !WB_DAT_I[`SIT_CTL_SLOTTED];
	end

	// Read mux, registered so the data is valid together with ack.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			WB_DAT_O <= 32'h0000_0000;
		else
		begin
			case (idx)
				`SIT_IDX_WAKE_LOW: WB_DAT_O <= {24'h00_0000, cfg.wake_match_value[7:0]};
				`SIT_IDX_WAKE_HIGH: WB_DAT_O <= {29'h0000_0000, cfg.wake_match_value[10:8]};
				`SIT_IDX_FINE_LOW: WB_DAT_O <= {24'h00_0000, cfg.fine_tick_count[7:0]};
				`SIT_IDX_FINE_HIGH: WB_DAT_O <= {24'h00_0000, cfg.fine_tick_count[15:8]};
				`SIT_IDX_COARSE0: WB_DAT_O <= {24'h00_0000, cfg.coarse_sleep_count[7:0]};
				`SIT_IDX_COARSE1: WB_DAT_O <= {24'h00_0000, cfg.coarse_sleep_count[15:8]};
				`SIT_IDX_COARSE2: WB_DAT_O <= {24'h00_0000, cfg.coarse_sleep_count[23:16]};
				`SIT_IDX_CONTROL: WB_DAT_O <= {24'h00_0000, 1'b0, cfg.beacon_run,
					cfg.slotted, 3'h0, cfg.low_power_clock_select};
				`SIT_IDX_MODE: WB_DAT_O <= {19'h0_0000, cfg.low_power_clock_divider,
					4'h0, cfg.beacon_order};
				`SIT_IDX_STATUS: WB_DAT_O <= {27'h000_0000, state, end_flag, wake_flag,
					state != sit_pkg::SIT_IDLE};
				default: WB_DAT_O <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************************************
	// Low-power clock source and divider
	// ****************************************************************
	logic [2:0] pin_sync; // Pin synchroniser; bit 0 is the raw capture.
	logic pin_level; // Filtered pin level.
	logic [$clog2(LP_INT_CYC + 1)-1:0] int_cnt; // Internal oscillator model.
	logic src_tick; // One tick of the selected source.
	logic [31:0] div_cnt; // Divider count.
	logic lp_tick; // One low-power clock period elapsed.

	// The pin counts as changed only once the second and third stage agree.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			pin_sync <= 3'h0;
			pin_level <= 1'b0;
		end
		else
		begin
			pin_sync <= {pin_sync[1:0], LP_CLK_PIN};
			if (pin_sync[1] == pin_sync[2])
				pin_level <= pin_sync[2];
		end
	end

	// Source selection; the internal source is a divide from the core clock.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			int_cnt <= '0;
			src_tick <= 1'b0;
		end
		else
		begin
			int_cnt <= (int_cnt == LP_INT_CYC[$bits(int_cnt)-1:0] - 1'b1) ? '0 : int_cnt + 1'b1;
			if (cfg.low_power_clock_select == `SIT_SEL_INTERNAL)
				src_tick <= int_cnt == '0;
			else
				src_tick <= pin_sync[1] && pin_sync[2] && !pin_level;
		end
	end

	// Divide by two to the divider field; a divider of zero passes every tick.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			div_cnt <= 32'h0000_0000;
			lp_tick <= 1'b0;
		end
		else
		begin
			lp_tick <= 1'b0;
			if (src_tick)
			begin
				if (div_cnt >= (32'h0000_0001 << cfg.low_power_clock_divider) - 32'h0000_0001)
				begin
					div_cnt <= 32'h0000_0000;
					lp_tick <= 1'b1;
				end
				else
					div_cnt <= div_cnt + 32'h0000_0001;
			end
		end
	end

	// ****************************************************************
	// Fine tick divider
	// ****************************************************************
	logic [$clog2(TICK_CYC + 1)-1:0] tick_cnt; // Cycles inside one fine tick.
	logic fine_tick; // One 50 ns tick elapsed.

	// Runs only in the fine phase so the first tick is a full one.
	always_ff @(posedge CLK)
	begin
		if (!RST_B || state != sit_pkg::SIT_FINE)
		begin
			tick_cnt <= '0;
			fine_tick <= 1'b0;
		end
		else
		begin
			fine_tick <= tick_cnt == TICK_CYC[$bits(tick_cnt)-1:0] - 1'b1;
			tick_cnt <= (tick_cnt == TICK_CYC[$bits(tick_cnt)-1:0] - 1'b1) ? '0
				: tick_cnt + 1'b1;
		end
	end

	// ****************************************************************
	// Interval sequencer
	// ****************************************************************
	logic [25:0] coarse_cnt; // Elapsed low-power periods.
	logic [15:0] fine_cnt; // Elapsed fine ticks.
	logic go; // Start of a new interval.

	assign go = start_req || (cfg.beacon_run && cfg.beacon_order != `SIT_BO_NONBEACON);
	assign wake_set = state == sit_pkg::SIT_COARSE && lp_tick
		&& coarse_cnt + 26'h000_0001 == {15'h0000, cfg.wake_match_value};
	assign end_set = state == sit_pkg::SIT_FINE && (fine_cnt == cfg.fine_tick_count
		|| (fine_tick && fine_cnt + 16'h0001 == cfg.fine_tick_count));

	// Coarse phase counts low-power periods, then the fine phase finishes it.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			state <= sit_pkg::SIT_IDLE;
			coarse_cnt <= 26'h000_0000;
			fine_cnt <= 16'h0000;
		end
		else
		begin
			case (state)
				sit_pkg::SIT_IDLE:
				begin
					coarse_cnt <= 26'h000_0000;
					fine_cnt <= 16'h0000;
					if (go)
						state <= sit_pkg::SIT_COARSE;
				end
				sit_pkg::SIT_COARSE:
				begin
					if (coarse_cnt == {coarse_top, cfg.coarse_sleep_count})
						state <= sit_pkg::SIT_FINE;
					else if (lp_tick)
						coarse_cnt <= coarse_cnt + 26'h000_0001;
				end
				sit_pkg::SIT_FINE:
				begin
					if (end_set)
						state <= sit_pkg::SIT_IDLE;
					else if (fine_tick)
						fine_cnt <= fine_cnt + 16'h0001;
				end
				default: state <= sit_pkg::SIT_IDLE;
			endcase
		end
	end

	// Outputs; the wake request holds until the period ends.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			OSC_WAKE <= 1'b0;
			PERIOD_END <= 1'b0;
			SLEEPING <= 1'b0;
		end
		else
		begin
			PERIOD_END <= end_set;
			SLEEPING <= state != sit_pkg::SIT_IDLE;
			if (wake_set)
				OSC_WAKE <= 1'b1;
			else if (state == sit_pkg::SIT_IDLE)
				OSC_WAKE <= 1'b0;
		end
	end

	// Sticky flags; a write of one clears, but a same-cycle event wins.
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			wake_flag <= 1'b0;
			end_flag <= 1'b0;
		end
		else
		begin
			if (wake_set)
				wake_flag <= 1'b1;
			else if (wr && idx == `SIT_IDX_STATUS && WB_DAT_I[`SIT_ST_WAKE])
				wake_flag <= 1'b0;
			if (end_set)
				end_flag <= 1'b1;
			else if (wr && idx == `SIT_IDX_STATUS && WB_DAT_I[`SIT_ST_END])
				end_flag <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: hdl/sit_defs.svh */
`ifndef SIT_DEFS_SVH
`define SIT_DEFS_SVH
// Register indexes; the byte address on the bus is four times the index.
`define SIT_IDX_WAKE_LOW 12'h222
`define SIT_IDX_WAKE_HIGH 12'h223
`define SIT_IDX_FINE_LOW 12'h224
`define SIT_IDX_FINE_HIGH 12'h225
`define SIT_IDX_COARSE0 12'h226
`define SIT_IDX_COARSE1 12'h227
`define SIT_IDX_COARSE2 12'h228
`define SIT_IDX_CONTROL 12'h240
`define SIT_IDX_MODE 12'h241
`define SIT_IDX_STATUS 12'h242
// Reset values.
`define SIT_WAKE_LOW_RST 8'h0a
`define SIT_WAKE_HIGH_RST 8'h00
`define SIT_BYTE_RST 8'h00
`define SIT_BO_RST 4'hf
// Field positions.
`define SIT_WAKE_HIGH_MSB 2
`define SIT_CTL_START 7
`define SIT_CTL_RUN 6
`define SIT_CTL_SLOTTED 5
`define SIT_CTL_SEL_LSB 0
`define SIT_MODE_BO_LSB 0
`define SIT_MODE_DIV_LSB 0
`define SIT_ST_RUNNING 0
`define SIT_ST_WAKE 1
`define SIT_ST_END 2
// Encodings.
`define SIT_BO_NONBEACON 4'hf
`define SIT_SEL_INTERNAL 2'h0
// Timing: clock period and fine tick length in ns; longest tick rounds down.
`define SIT_CLK_NS 4
`define SIT_TICK_NS 50
`define SIT_TICK_CYC (`SIT_TICK_NS / `SIT_CLK_NS)
// Internal low-power oscillator period in clock cycles (100 kHz at 250 MHz).
`define SIT_LP_INT_NS 10000
`define SIT_LP_INT_CYC (`SIT_LP_INT_NS / `SIT_CLK_NS)
`endif

/* File: hdl/sit_pkg.sv */
package sit_pkg;
	// Sequencer states.
	typedef enum logic [1:0]
	{
		SIT_IDLE = 2'b00,
		SIT_COARSE = 2'b01,
		SIT_FINE = 2'b10
	} sit_state_t;
	// Software-visible configuration.
	typedef struct packed
	{
		logic [10:0] wake_match_value;
		logic [15:0] fine_tick_count;
		logic [23:0] coarse_sleep_count;
		logic [3:0] beacon_order;
		logic slotted;
		logic beacon_run;
		logic [1:0] low_power_clock_select;
		logic [4:0] low_power_clock_divider;
	} sit_cfg_t;
endpackage

/* File: test/sit_timer_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************
// Port checks of the sleep interval timer.
// ****************
module sit_timer_sva
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic [13:0] WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK,
	input wire logic LP_CLK_PIN,
	input wire logic OSC_WAKE,
	input wire logic PERIOD_END,
	input wire logic SLEEPING
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	property p_ack_next;
		WB_CYC && WB_STB && !WB_ACK |=> WB_ACK;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_drop;
		WB_ACK |=> !WB_ACK;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack held");
	property p_hole_zero;
		WB_ACK && !WB_WE && WB_ADR[13:2] == 12'h300 |-> WB_DAT_O == 32'h0;
	endproperty
	a_hole_zero: assert property (p_hole_zero) else $error("hole not zero");
	property p_end_pulse;
		PERIOD_END |=> !PERIOD_END;
	endproperty
	a_end_pulse: assert property (p_end_pulse) else $error("end held");
	property p_end_idle;
		PERIOD_END |-> SLEEPING ##1 !SLEEPING;
	endproperty
	a_end_idle: assert property (p_end_idle) else $error("end not at idle");
	property p_start_quiet;
		$rose(SLEEPING) |-> !PERIOD_END ##1 SLEEPING;
	endproperty
	a_start_quiet: assert property (p_start_quiet) else $error("end too soon");
	property p_wake_asleep;
		OSC_WAKE |-> SLEEPING || $past(SLEEPING);
	endproperty
	a_wake_asleep: assert property (p_wake_asleep) else $error("wake idle");
	property p_wake_fall;
		$fell(OSC_WAKE) |-> $past(PERIOD_END) or ##[0:1] PERIOD_END;
	endproperty
	a_wake_fall: assert property (p_wake_fall) else $error("wake fell early");
endmodule
bind sit_timer sit_timer_sva sit_timer_sva_i (.CLK(CLK), .RST_B(RST_B), .WB_CYC(WB_CYC),
	.WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK), .LP_CLK_PIN(LP_CLK_PIN), .OSC_WAKE(OSC_WAKE),
	.PERIOD_END(PERIOD_END), .SLEEPING(SLEEPING));
`default_nettype wire

/* File: test/test_sleep_interval_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module test_sleep_interval_timer;
	logic CLK = 1'b0, RST_B = 1'b0, WB_CYC = 1'b0, WB_STB = 1'b0, WB_WE = 1'b0;
	logic LP_CLK_PIN = 1'b0, WB_ACK, OSC_WAKE, PERIOD_END, SLEEPING, woke;
	logic [13:0] WB_ADR = 14'h0;
	logic [3:0] WB_SEL = 4'h0;
	logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
	logic [15:0] rd;
	logic [7:0] rst_val [7] = '{8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	int err_count = 0, n_checks = 0, lp_div = 0, cyc, ends, p;
	// ****************
	// Clocks and the design.
	// ****************
	always #2 CLK = ~CLK;
	// External slow clock with a ten-cycle period, unrelated to any count.
	always @(posedge CLK)
	begin
		lp_div <= (lp_div == 4) ? 0 : lp_div + 1;
		if (lp_div == 4)
			LP_CLK_PIN <= ~LP_CLK_PIN;
	end
	// A short internal period keeps the coarse phase brief.
	sit_timer #(.TICK_CYC(12), .LP_INT_CYC(4)) sit_timer_i (.CLK(CLK), .RST_B(RST_B),
		.WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE), .WB_ADR(WB_ADR), .WB_SEL(WB_SEL),
		.WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK), .LP_CLK_PIN(LP_CLK_PIN),
		.OSC_WAKE(OSC_WAKE), .PERIOD_END(PERIOD_END), .SLEEPING(SLEEPING));
	// ****************
	// Tasks.
	// ****************
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic hang;
		err_count++;
		$display("BAD %0t wait ran out", $time);
		print_verdict();
	endtask
	// One classic cycle; the request holds until ack is sampled.
	task automatic wb(input logic we, input logic [11:0] idx, input logic [15:0] d);
		int n = 0;
		WB_CYC <= 1'b1;
		WB_STB <= 1'b1;
		WB_WE <= we;
		WB_ADR <= {idx, 2'b00};
		WB_SEL <= 4'h1;
		WB_DAT_I <= {16'h0, d};
		do
		begin
			@(posedge CLK);
			n++;
		end
		while (WB_ACK !== 1'b1 && n < 100);
		if (WB_ACK !== 1'b1)
			hang();
		rd = WB_DAT_O[15:0];
		WB_CYC <= 1'b0;
		WB_STB <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic rchk(input logic [11:0] idx, input logic [15:0] exp);
		wb(1'b0, idx, 16'h0);
		chk(rd, exp);
	endtask
	// Counts end pulses and sleep over a fixed span.
	task automatic watch(input int n);
		ends = 0;
		woke = 1'b0;
		repeat (n)
		begin
			@(posedge CLK);
			ends += (PERIOD_END === 1'b1);
			woke = woke | (SLEEPING === 1'b1);
		end
	endtask
	// Starts one interval, measures it and checks it against the given span.
	task automatic run(input logic [7:0] n, f, input logic [15:0] mode, ctl, input int lo, hi);
		wb(1'b1, 12'h226, {8'h0, n});
		wb(1'b1, 12'h224, {8'h0, f});
		wb(1'b1, 12'h241, mode);
		wb(1'b1, 12'h240, ctl);
		cyc = 0;
		woke = 1'b0;
		while (PERIOD_END !== 1'b1 && cyc < 3000)
		begin
			@(posedge CLK);
			cyc++;
			woke = woke | (OSC_WAKE === 1'b1);
		end
		if (PERIOD_END !== 1'b1)
			hang();
		chk({15'h0, cyc >= lo && cyc <= hi}, 16'h1);
		@(posedge CLK);
	endtask
	// ****************
	// Sequence.
	// ****************
	initial
	begin
		repeat (4) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		for (int i = 0; i < 7; i++)
			rchk(12'h222 + 12'(i), {8'h0, rst_val[i]});
		$display("reset values done");
		wb(1'b1, 12'h223, 16'h0005);
		rchk(12'h223, 16'h0005);
		for (int i = 0; i < 5; i++)
			wb(1'b1, 12'h224 + 12'(i), 16'h00a0 + 16'(i));
		for (int i = 0; i < 5; i++)
			rchk(12'h224 + 12'(i), 16'h00a0 + 16'(i));
		wb(1'b1, 12'h300, 16'h00ff);
		rchk(12'h300, 16'h0000);
		$display("register access done");
		wb(1'b1, 12'h223, 16'h0000);
		wb(1'b1, 12'h224, 16'h0000);
		wb(1'b1, 12'h225, 16'h0000);
		wb(1'b1, 12'h227, 16'h0000);
		wb(1'b1, 12'h228, 16'h0000);
		wb(1'b1, 12'h222, 16'h0002);
		// Eight coarse ticks then one fine tick, for dividers one to four.
		// The internal source is never run undivided, as software must not.
		for (int d = 1; d < 5; d++)
		begin
			p = 4 << d;
			run(8'h08, 8'h01, {3'h0, 5'(d), 8'h0f}, 16'h0080, 7 * p, 8 * p + 32);
			chk({15'h0, woke}, 16'h1);
		end
		// Both sticky flags are up after the runs, and a write of ones clears them.
		rchk(12'h242, 16'h0006);
		wb(1'b1, 12'h242, 16'h0006);
		rchk(12'h242, 16'h0000);
		rchk(12'h240, 16'h0000);
		run(8'h08, 8'h01, 16'h000f, 16'h0081, 70, 112);
		run(8'h02, 8'h04, 16'h010f, 16'h0080, 52, 100);
		wb(1'b1, 12'h222, 16'h0020);
		run(8'h08, 8'h00, 16'h010f, 16'h0080, 56, 96);
		chk({15'h0, woke}, 16'h0);
		$display("non-beacon sleep done");
		wb(1'b1, 12'h241, 16'h0103);
		wb(1'b1, 12'h240, 16'h0080);
		watch(40);
		chk({15'h0, woke}, 16'h0);
		wb(1'b1, 12'h241, 16'h000f);
		wb(1'b1, 12'h240, 16'h00a0);
		watch(40);
		chk({15'h0, woke}, 16'h0);
		$display("refused begin done");
		wb(1'b1, 12'h226, 16'h0001);
		wb(1'b1, 12'h224, 16'h0001);
		wb(1'b1, 12'h241, 16'h0103);
		wb(1'b1, 12'h240, 16'h0040);
		watch(300);
		chk({15'h0, ends >= 2}, 16'h1);
		$display("beacon restart done");
		print_verdict();
	end
endmodule
`default_nettype wire
